// ==== rtl/dlo_regs.sv ====
// Differential line-out volume registers behind an APB slave.
// Assumes zero-cross indications arrive asynchronously from the analogue side.

// Functional notes
// - Bit 8 mutes channel; resets muted
// - Writing bit 7 applies both volumes together
// - Update bit is write-only, reads zero
// - Bit 6 enables zero-cross gating; resets 0
// - Gain code 0 is -57dB, 1dB steps
// - Gain fields reset to 0dB code
// - Right register mirrors left register layout
module dlo_regs #(
    parameter int ZC_TIMEOUT_CYCLES = dlo_pkg::ZC_TIMEOUT_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dlo_pkg::ADDR_W-1:0] paddr,
    input wire logic [dlo_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [dlo_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic left_zero_cross,
    input wire logic right_zero_cross,
    output logic left_diff_mute,
    output logic right_diff_mute,
    output logic [dlo_pkg::GAIN_W-1:0] left_diff_gain,
    output logic [dlo_pkg::GAIN_W-1:0] right_diff_gain
);

    localparam int NCH = 2;
    localparam int CNT_W = $clog2(ZC_TIMEOUT_CYCLES + 1);

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic pready_reg;
    logic pslverr_reg;
    logic [dlo_pkg::DATA_W-1:0] prdata_reg;

    wire setup_phase = psel & ~penable;
    wire access_done = psel & penable & pready_reg;
    wire sel_left = (paddr == dlo_pkg::LEFT_REG_ADDR);
    wire sel_right = (paddr == dlo_pkg::RIGHT_REG_ADDR);
    wire sel_status = (paddr == dlo_pkg::STATUS_REG_ADDR);
    wire addr_hit = sel_left | sel_right | sel_status;
    // The status register is read-only; a write to it is flagged as an error.
    wire bad_access = ~addr_hit | (sel_status & pwrite);
    wire wr_ok = access_done & pwrite & ~bad_access;
    wire lane0 = pstrb[0];
    wire lane1 = pstrb[1];

    wire [NCH-1:0] ch_write = {wr_ok & sel_right, wr_ok & sel_left};

    // ----------------------------------------------------------------
    // Channel control state
    // ----------------------------------------------------------------
    logic [NCH-1:0] mute_reg;
    logic [NCH-1:0] mute_next;
    logic [NCH-1:0] zc_reg;
    logic [NCH-1:0] zc_next;
    logic [dlo_pkg::GAIN_W-1:0] pend_reg [NCH];
    logic [dlo_pkg::GAIN_W-1:0] pend_next [NCH];
    logic apply_reg;
    logic apply_next;
    logic [dlo_pkg::GAIN_W-1:0] applied [NCH];
    logic [NCH-1:0] waiting;
    logic [NCH-1:0] zc_in;
    logic [NCH-1:0] zc_pulse;

    assign zc_in = {right_zero_cross, left_zero_cross};

    assign apply_next = wr_ok & (sel_left | sel_right) & lane0 & pwdata[dlo_pkg::APPLY_BIT];

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            logic sync1_reg;
            logic sync2_reg;
            logic prev_reg;

            always_comb
            begin
                mute_next[ch] = mute_reg[ch];
                zc_next[ch] = zc_reg[ch];
                pend_next[ch] = pend_reg[ch];
                if (ch_write[ch] && lane1)
                begin
                    mute_next[ch] = pwdata[dlo_pkg::MUTE_BIT];
                end
                if (ch_write[ch] && lane0)
                begin
                    zc_next[ch] = pwdata[dlo_pkg::ZC_BIT];
                    pend_next[ch] = pwdata[dlo_pkg::GAIN_LSB +: dlo_pkg::GAIN_W];
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mute_reg[ch] <= dlo_pkg::MUTE_RST;
                    zc_reg[ch] <= dlo_pkg::ZC_RST;
                    pend_reg[ch] <= dlo_pkg::GAIN_RST;
                end
                else
                begin
                    mute_reg[ch] <= mute_next[ch];
                    zc_reg[ch] <= zc_next[ch];
                    pend_reg[ch] <= pend_next[ch];
                end
            end

            // The comparator toggles on every sign change, so either edge is a crossing.
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                    prev_reg <= 1'b0;
                end
                else
                begin
                    sync1_reg <= zc_in[ch];
                    sync2_reg <= sync1_reg;
                    prev_reg <= sync2_reg;
                end
            end

            assign zc_pulse[ch] = sync2_reg ^ prev_reg;

            // code passed unchanged to gain stage
            dlo_gain_stage #(
                .GAIN_W(dlo_pkg::GAIN_W),
                .TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES),
                .CNT_W(CNT_W)
            ) u_stage (
                .pclk(pclk),
                .presetn(presetn),
                .apply_pulse(apply_reg),
                .target_gain(pend_reg[ch]),
                .zc_en(zc_reg[ch]),
                .zc_pulse(zc_pulse[ch]),
                .applied_gain(applied[ch]),
                .waiting(waiting[ch])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Update strobe
    // ----------------------------------------------------------------
    // Delayed one cycle so both pending values, including the one just written, are settled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            apply_reg <= dlo_pkg::APPLY_RST;
        end
        else
        begin
            apply_reg <= apply_next;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire [dlo_pkg::DATA_W-1:0] left_rd;
    wire [dlo_pkg::DATA_W-1:0] right_rd;
    wire [dlo_pkg::DATA_W-1:0] status_rd;
    wire [dlo_pkg::DATA_W-1:0] rd_mux;

    assign left_rd = {23'h0, mute_reg[0], 1'b0, zc_reg[0], pend_reg[0]};
    assign right_rd = {23'h0, mute_reg[1], 1'b0, zc_reg[1], pend_reg[1]};
    assign status_rd = {14'h0, waiting[1], waiting[0], 2'h0, applied[1], 2'h0, applied[0]};
    assign rd_mux = sel_left ? left_rd :
                    sel_right ? right_rd :
                    sel_status ? status_rd : '0;

    wire [dlo_pkg::DATA_W-1:0] prdata_next = (setup_phase && !pwrite) ? rd_mux : prdata_reg;
    // One wait-free access: ready rises in the access phase and drops after it.
    wire pready_next = setup_phase;
    wire pslverr_next = setup_phase & bad_access;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= '0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign left_diff_mute = mute_reg[0];
    assign right_diff_mute = mute_reg[1];
    assign left_diff_gain = applied[0];
    assign right_diff_gain = applied[1];

endmodule

// ==== rtl/dlo_pkg.sv ====
// Constants for the differential line-out volume register bank.
// Assumes a 50 MHz APB clock and a 12-bit byte address bus.
package dlo_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [7:0] LEFT_REG_IDX = 8'h3e;
    localparam logic [7:0] RIGHT_REG_IDX = 8'h3f;
    localparam logic [7:0] STATUS_REG_IDX = 8'h40;
    localparam logic [ADDR_W-1:0] LEFT_REG_ADDR = {2'h0, LEFT_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] RIGHT_REG_ADDR = {2'h0, RIGHT_REG_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] STATUS_REG_ADDR = {2'h0, STATUS_REG_IDX, 2'h0};

    // ----------------------------------------------------------------
    // Channel control register fields
    // ----------------------------------------------------------------
    localparam int MUTE_BIT = 8;
    localparam int APPLY_BIT = 7;
    localparam int ZC_BIT = 6;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 6;
    localparam logic MUTE_RST = 1'h1;
    localparam logic APPLY_RST = 1'h0;
    localparam logic ZC_RST = 1'h0;
    localparam logic [GAIN_W-1:0] GAIN_RST = 6'h39;
    localparam logic [GAIN_W-1:0] GAIN_MIN_CODE = 6'h00;
    localparam logic [GAIN_W-1:0] GAIN_UNITY_CODE = 6'h39;
    localparam logic [GAIN_W-1:0] GAIN_MAX_CODE = 6'h3f;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STAT_LEFT_GAIN_LSB = 0;
    localparam int STAT_RIGHT_GAIN_LSB = 8;
    localparam int STAT_LEFT_WAIT_BIT = 16;
    localparam int STAT_RIGHT_WAIT_BIT = 17;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int ZC_TIMEOUT_US = 1000;
    localparam int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_US * CLK_MHZ;

endpackage

// ==== rtl/dlo_gain_stage.sv ====
// One channel's applied-gain stage with optional zero-cross gating.
// Assumes apply_pulse is one cycle and zc_pulse is already synchronised.
module dlo_gain_stage #(
    parameter int GAIN_W = 6,
    parameter int TIMEOUT_CYCLES = 50000,
    parameter int CNT_W = 17
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic apply_pulse,
    input wire logic [GAIN_W-1:0] target_gain,
    input wire logic zc_en,
    input wire logic zc_pulse,
    output logic [GAIN_W-1:0] applied_gain,
    output logic waiting
);

    logic [GAIN_W-1:0] applied_reg;
    logic [GAIN_W-1:0] applied_next;
    logic [GAIN_W-1:0] held_reg;
    logic [GAIN_W-1:0] held_next;
    logic waiting_reg;
    logic waiting_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

    wire timed_out = (cnt_reg == CNT_LAST);
    // A silent channel never crosses zero, so the timeout keeps a change from hanging.
    wire release_now = waiting_reg & (zc_pulse | timed_out | ~zc_en);

    always_comb
    begin
        applied_next = applied_reg;
        held_next = held_reg;
        waiting_next = waiting_reg;
        cnt_next = waiting_reg ? cnt_reg + 1'b1 : '0;
        if (apply_pulse)
        begin
            if (zc_en)
            begin
                held_next = target_gain;
                waiting_next = 1'b1;
                cnt_next = '0;
            end
            else
            begin
                applied_next = target_gain;
                waiting_next = 1'b0;
            end
        end
        else if (release_now)
        begin
            applied_next = held_reg;
            waiting_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            applied_reg <= dlo_pkg::GAIN_RST;
            held_reg <= dlo_pkg::GAIN_RST;
            waiting_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else
        begin
            applied_reg <= applied_next;
            held_reg <= held_next;
            waiting_reg <= waiting_next;
            cnt_reg <= cnt_next;
        end
    end

    assign applied_gain = applied_reg;
    assign waiting = waiting_reg;

endmodule

// ==== test/dlo_regs_props.sv ====
// Concurrent checks on the ports of the line-out volume register bank.
// Assumes it is bound to dlo_regs and runs in the APB clock domain.
module dlo_regs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic left_zero_cross,
    input wire logic right_zero_cross,
    input wire logic left_diff_mute,
    input wire logic right_diff_mute,
    input wire logic [5:0] left_diff_gain,
    input wire logic [5:0] right_diff_gain
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Shared sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pready && !pslverr;
    wire logic setup = psel && !penable;
    wire logic mapped = paddr == dlo_pkg::LEFT_REG_ADDR || paddr == dlo_pkg::RIGHT_REG_ADDR
        || paddr == dlo_pkg::STATUS_REG_ADDR;
    sequence s_wr_left;
        acc && pwrite && paddr == dlo_pkg::LEFT_REG_ADDR;
    endsequence
    sequence s_wr_right;
        acc && pwrite && paddr == dlo_pkg::RIGHT_REG_ADDR;
    endsequence
    sequence s_left_quiet;
        $stable(left_zero_cross) [*4];
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_reset_values: assert property (
        $rose(presetn) |-> left_diff_mute && right_diff_mute
        && left_diff_gain == dlo_pkg::GAIN_RST && right_diff_gain == dlo_pkg::GAIN_RST)
        else $error("outputs wrong after reset");
    a_mute_left: assert property (s_wr_left ##0 pstrb[1] |->
        ##2 left_diff_mute == $past(pwdata[8], 2)) else $error("left mute not applied");
    a_mute_right: assert property (s_wr_right ##0 pstrb[1] |->
        ##2 right_diff_mute == $past(pwdata[8], 2)) else $error("right mute not applied");
    a_apply_left: assert property (s_wr_left ##0 (pstrb[0] && pwdata[7:6] == 2'h2) |->
        ##3 left_diff_gain == $past(pwdata[5:0], 3)) else $error("left gain not applied");
    a_update_reads_zero: assert property (
        acc && !pwrite && paddr != dlo_pkg::STATUS_REG_ADDR
        |-> prdata[31:9] == 23'h0 && !prdata[7]) else $error("update bit reads back");
    a_zc_holds_gain: assert property (s_left_quiet ##0 s_wr_left
        ##0 pwdata[7:6] == 2'h3 |=> $stable(left_diff_gain) [*2])
        else $error("gated gain moved early");
    a_pready_after_setup: assert property (setup |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    // A refused write leaves the read data register as it was; only a read returns zero.
    a_err_unmapped: assert property (setup && !mapped |=> pready && pslverr
        && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
endmodule

// ==== test/dlo_regs_tb.sv ====
// Self-checking bench for the line-out volume register bank.
// Assumes dlo_pkg, dlo_regs and the checker are compiled before it.
module dlo_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic left_zero_cross = 1'b0;
    logic right_zero_cross = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic left_diff_mute;
    logic right_diff_mute;
    logic [5:0] left_diff_gain;
    logic [5:0] right_diff_gain;
    logic [31:0] rdat;
    int mismatches = 0;
    int tests_run = 0;
    localparam logic [11:0] LA = dlo_pkg::LEFT_REG_ADDR;
    localparam logic [11:0] RA = dlo_pkg::RIGHT_REG_ADDR;

    // A short 200-cycle crossing timeout keeps the timeout test brief.
    dlo_regs #(.ZC_TIMEOUT_CYCLES(200)) dlo_regs_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .left_zero_cross(left_zero_cross), .right_zero_cross(right_zero_cross),
        .left_diff_mute(left_diff_mute), .right_diff_mute(right_diff_mute),
        .left_diff_gain(left_diff_gain), .right_diff_gain(right_diff_gain));

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic err, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a transfer that is never answered.
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        chk("pslverr", 32'(err), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, LA, 32'h0, 1'b0, rdat);
        chk("left reg", 32'h139, rdat);
        apb(1'b0, RA, 32'h0, 1'b0, rdat);
        chk("right reg", 32'h139, rdat);
        chk("mutes", 32'h3, 32'({left_diff_mute, right_diff_mute}));
        $display("reset test done");
    endtask

    task automatic t_apply;
        apb(1'b1, LA, 32'h100, 1'b0, rdat);
        repeat (4) @(posedge pclk);
        chk("pending gain", 32'h39, 32'(left_diff_gain));
        apb(1'b1, RA, 32'h1bf, 1'b0, rdat);
        repeat (3) @(posedge pclk);
        chk("both gains", 32'h03f, 32'({left_diff_gain, right_diff_gain}));
        apb(1'b0, RA, 32'h0, 1'b0, rdat);
        chk("right readback", 32'h13f, rdat);
        $display("apply test done");
    endtask

    task automatic t_mute;
        apb(1'b1, LA, 32'h0b9, 1'b0, rdat);
        repeat (3) @(posedge pclk);
        chk("mutes", 32'h1, 32'({left_diff_mute, right_diff_mute}));
        chk("left gain", 32'h39, 32'(left_diff_gain));
        apb(1'b1, RA, 32'h0bf, 1'b0, rdat);
        repeat (3) @(posedge pclk);
        chk("mutes", 32'h0, 32'({left_diff_mute, right_diff_mute}));
        $display("mute test done");
    endtask

    task automatic t_zero_cross;
        int n;
        apb(1'b1, LA, 32'h0e0, 1'b0, rdat);
        repeat (6) @(posedge pclk);
        chk("gated gain", 32'h39, 32'(left_diff_gain));
        left_zero_cross <= 1'b1;
        right_zero_cross <= 1'b1;
        n = 0;
        do @(posedge pclk); while (left_diff_gain !== 6'h20 && ++n < 12);
        chk("crossing gain", 32'h20, 32'(left_diff_gain));
        apb(1'b0, dlo_pkg::STATUS_REG_ADDR, 32'h0, 1'b0, rdat);
        chk("status", 32'h3f20, rdat);
        $display("zero cross test done");
    endtask

    // Lanes write their own fields, and a gated change with no crossing waits for the timeout.
    task automatic t_lanes_timeout;
        pstrb <= 4'h2;
        apb(1'b1, LA, 32'h100, 1'b0, rdat);
        pstrb <= 4'h1;
        apb(1'b0, LA, 32'h0, 1'b0, rdat);
        chk("mute lane only", 32'h160, rdat);
        apb(1'b1, LA, 32'h0d0, 1'b0, rdat);
        pstrb <= 4'hf;
        repeat (190) @(posedge pclk);
        chk("gain before timeout", 32'h20, 32'(left_diff_gain));
        repeat (20) @(posedge pclk);
        chk("gain after timeout", 32'h10, 32'(left_diff_gain));
        chk("mute kept", 32'h1, 32'(left_diff_mute));
        $display("lane and timeout test done");
    endtask

    task automatic t_errors;
        apb(1'b0, 12'h000, 32'h0, 1'b1, rdat);
        chk("unmapped read", 32'h0, rdat);
        apb(1'b1, dlo_pkg::STATUS_REG_ADDR, 32'h0, 1'b1, rdat);
        $display("error test done");
    endtask

    task automatic summarize;
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_apply();
        t_mute();
        t_zero_cross();
        t_lanes_timeout();
        t_errors();
        summarize();
    end

    // The whole run needs well under a thousand cycles.
    initial
    begin
        #40000;
        mismatches++;
        summarize();
    end
endmodule

bind dlo_regs dlo_regs_props dlo_regs_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .left_zero_cross(left_zero_cross),
    .right_zero_cross(right_zero_cross), .left_diff_mute(left_diff_mute),
    .right_diff_mute(right_diff_mute), .left_diff_gain(left_diff_gain),
    .right_diff_gain(right_diff_gain));
